// >>> rotate_and_set_file_ops_tb_top.sv
// Purpose: Self-checking bench for the rotate and set datapath over AXI4-Lite
// Assumes: Fixed seed; clock enable drawn at random after reset
// Notes:   Expected register values worked out by the bench
`timescale 1ns/1ns
module rotate_and_set_file_ops_tb_top;
   import rsf_pkg::*;
   logic         clk;
   logic         srst;
   logic         ce;
   rsf_axi_req_t req;
   rsf_axi_rsp_t rsp;
   int           errors;
   int           samples_checked;
   integer       seed;
   logic [31:0]  rv;
   logic [1:0]   rr;
   logic [31:0]  r;

   rsf_core rsf_core_i (.clk(clk), .srst(srst), .ce(ce), .axi_req(req), .axi_rsp(rsp));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
      ce <= srst | (($random(seed) & 3) != 0);

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic got;
      got = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      while (!got)
      begin
         @(posedge clk);
         if (ce && rsp.awready)
            req.awvalid <= 1'b0;
         if (ce && rsp.wready)
            req.wvalid <= 1'b0;
         if (ce && rsp.bvalid)
         begin
            resp = rsp.bresp;
            got = 1'b1;
            req.bready <= 1'b0;
         end
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic got;
      got = 1'b0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      while (!got)
      begin
         @(posedge clk);
         if (ce && rsp.arready)
            req.arvalid <= 1'b0;
         if (ce && rsp.rvalid)
         begin
            d = rsp.rdata;
            resp = rsp.rresp;
            got = 1'b1;
            req.rready <= 1'b0;
         end
      end
   endtask : rd

   task automatic run_one(input int k, input logic d, input logic a, input logic [7:0] f,
      input logic [3:0] bank, input logic [7:0] fv, input logic [7:0] wv, input logic [2:0] st);
      logic [15:0] ins;
      logic [7:0]  res;
      logic [7:0]  er;
      logic [7:0]  ew;
      logic [2:0]  es;
      logic [11:0] fa;
      ins = (k == 0) ? {OP_RLNC, d, a, f} : (k == 1) ? {OP_RRC, d, a, f} :
            (k == 2) ? {OP_RRNC, d, a, f} : (k == 3) ? {OP_SET_REGISTER_ALL_ONES, a, f} : {6'h3f, d, a, f};
      res = (k == 0) ? {fv[6:0], fv[7]} : (k == 1) ? {st[ST_C], fv[7:1]} : {fv[0], fv[7:1]};
      er = fv;
      ew = wv;
      es = st;
      if (k < 3)
      begin
         es[ST_N] = res[7];
         es[ST_Z] = (res == BYTE_ZERO);
         if (k == 1)
            es[ST_C] = fv[0];
         if (d)
            er = res;
         else
            ew = res;
      end
      else if (k == 3)
         er = ALL_ONES;
      fa = a ? {bank, f} : {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
      wr(OFS_BANK, {28'h0, bank}, rr);
      wr(OFS_WREG, {24'h0, wv}, rr);
      wr(OFS_FDATA, {24'h0, fv}, rr);
      wr(OFS_STATUS, {29'h0, st}, rr);
      wr(OFS_INSTR, {16'h0, ins}, rr);
      rv = 32'h100;
      while (rv[ST_BUSY] !== 1'b0)
         rd(OFS_STATUS, rv, rr);
      chk(rv, {22'h0, k == 4, 1'b0, 5'h0, es});
      rd(OFS_FDATA, rv, rr);
      chk(rv, {24'h0, er});
      rd(OFS_WREG, rv, rr);
      chk(rv, {24'h0, ew});
      rd(OFS_FADDR, rv, rr);
      if (k != 4)
         chk(rv, {20'h0, fa});
   endtask : run_one

   initial
   begin
      seed = 32'haa7fe236;
      errors = 0;
      samples_checked = 0;
      req = '0;
      srst = 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         rd(8'(i * 4), rv, rr);
         chk(rv, 32'h0);
      end
      wr(8'h40, 32'h1234, rr);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      rd(8'h40, rv, rr);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      run_one(0, 1'b1, 1'b0, 8'h10, 4'h3, 8'hab, 8'h00, 3'h0);
      run_one(1, 1'b0, 1'b0, 8'h7f, 4'h3, 8'he6, 8'h11, 3'h0);
      run_one(2, 1'b1, 1'b0, 8'h80, 4'h5, 8'hd7, 8'h22, 3'h1);
      run_one(2, 1'b0, 1'b1, 8'h80, 4'h5, 8'hd7, 8'h22, 3'h1);
      run_one(3, 1'b0, 1'b1, 8'h2a, 4'h9, 8'h5a, 8'h33, 3'h7);
      run_one(1, 1'b1, 1'b1, 8'hff, 4'hf, 8'h01, 8'h44, 3'h0);
      run_one(0, 1'b1, 1'b1, 8'h00, 4'h0, 8'h00, 8'h00, 3'h5);
      run_one(4, 1'b1, 1'b1, 8'h05, 4'h2, 8'h66, 8'h77, 3'h2);
      for (int i = 0; i < 40; i++)
      begin
         r = $random(seed);
         run_one(int'(r[2:0]) % 5, r[3], r[4], r[15:8], r[19:16], r[27:20],
            r[7:0] ^ r[31:24], r[30:28]);
      end
      conclude();
   end

   initial
   begin
      #(60000 * 10);
      errors++;
      conclude();
   end
endmodule : rotate_and_set_file_ops_tb_top

// >>> rsf_core.sv
// Purpose: Rotate and set-all-ones execution datapath behind an AXI4-Lite slave
// Assumes: Software loads the addressed byte into the operand register first
// Notes:   Bus writes to datapath registers are ignored while an instruction runs
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module rsf_core
(
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            ce,
   input  wire rsf_pkg::rsf_axi_req_t axi_req,
   output      rsf_pkg::rsf_axi_rsp_t axi_rsp
);
   import rsf_pkg::*;

   rsf_phase_t               phase;
   rsf_kind_t                kind;
   logic [INSTR_W-1:0]       instr;
   logic [BYTE_W-1:0]        wreg;
   logic [BANK_W-1:0]        bank_select_register;
   logic                     flag_c;
   logic                     flag_z;
   logic                     flag_n;
   logic                     unsup;
   logic [BYTE_W-1:0]        fdata;
   logic [FADDR_W-1:0]       faddr;
   logic [BYTE_W-1:0]        operand;
   logic [BYTE_W-1:0]        result;
   logic                     res_c;
   logic                     aw_got;
   logic                     w_got;
   logic [ADDR_W-1:0]        aw_addr;
   logic [DATA_W-1:0]        w_data;
   logic [3:0]               w_strb;
   logic                     wr_fire;
   rsf_sel_t                 wr_sel;
   rsf_sel_t                 rd_sel;
   logic                     busy;
   logic [DATA_W-1:0]        rd_word;

   // Address decode shared by read and write paths
   function automatic rsf_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
      rsf_sel_t s;
      s = SEL_NONE;
      if (addr == OFS_INSTR)
         s = SEL_INSTR;
      else if (addr == OFS_WREG)
         s = SEL_WREG;
      else if (addr == OFS_BANK)
         s = SEL_BANK;
      else if (addr == OFS_STATUS)
         s = SEL_STATUS;
      else if (addr == OFS_FDATA)
         s = SEL_FDATA;
      else if (addr == OFS_FADDR)
         s = SEL_FADDR;
      return s;
   endfunction : decode_addr

   // Byte-lane merge of write data over an old value
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0]        strb);
      logic [DATA_W-1:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            m[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return m;
   endfunction : merge

   assign busy    = (phase != PH_IDLE);
   assign wr_fire = aw_got && w_got && !axi_rsp.bvalid;
   assign wr_sel  = decode_addr(aw_addr);
   assign rd_sel  = decode_addr(axi_req.araddr);

   // All bus channels in one process; write address and data taken in either order
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_got          <= 1'b0;
         w_got           <= 1'b0;
         aw_addr         <= '0;
         w_data          <= '0;
         w_strb          <= '0;
         axi_rsp.awready <= 1'b1;
         axi_rsp.wready  <= 1'b1;
         axi_rsp.bvalid  <= 1'b0;
         axi_rsp.bresp   <= RESP_OKAY;
         axi_rsp.arready <= 1'b1;
         axi_rsp.rvalid  <= 1'b0;
         axi_rsp.rdata   <= '0;
         axi_rsp.rresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (axi_req.awvalid && axi_rsp.awready)
         begin
            aw_got          <= 1'b1;
            aw_addr         <= axi_req.awaddr;
            axi_rsp.awready <= 1'b0;
         end
         if (axi_req.wvalid && axi_rsp.wready)
         begin
            w_got          <= 1'b1;
            w_data         <= axi_req.wdata;
            w_strb         <= axi_req.wstrb;
            axi_rsp.wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            axi_rsp.bvalid <= 1'b1;
            axi_rsp.bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (axi_rsp.bvalid && axi_req.bready)
         begin
            axi_rsp.bvalid  <= 1'b0;
            axi_rsp.awready <= 1'b1;
            axi_rsp.wready  <= 1'b1;
         end
         if (axi_req.arvalid && axi_rsp.arready)
         begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid  <= 1'b1;
            axi_rsp.rdata   <= rd_word;
            axi_rsp.rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (axi_rsp.rvalid && axi_req.rready)
         begin
            axi_rsp.rvalid  <= 1'b0;
            axi_rsp.arready <= 1'b1;
         end
      end
   end

   // Read data mux
   always_comb
   begin
      rd_word = '0;
      if (rd_sel == SEL_INSTR)
         rd_word[INSTR_W-1:0] = instr;
      else if (rd_sel == SEL_WREG)
         rd_word[BYTE_W-1:0] = wreg;
      else if (rd_sel == SEL_BANK)
         rd_word[BANK_W-1:0] = bank_select_register;
      else if (rd_sel == SEL_STATUS)
      begin
         rd_word[ST_C]     = flag_c;
         rd_word[ST_Z]     = flag_z;
         rd_word[ST_N]     = flag_n;
         rd_word[ST_BUSY]  = busy;
         rd_word[ST_UNSUP] = unsup;
      end
      else if (rd_sel == SEL_FDATA)
         rd_word[BYTE_W-1:0] = fdata;
      else if (rd_sel == SEL_FADDR)
         rd_word[FADDR_W-1:0] = faddr;
   end

   // Instruction cycle sequencer
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phase <= PH_IDLE;
         instr <= '0;
      end
      else if (ce)
      begin
         case (phase)
            PH_IDLE:
            begin
               if (wr_fire && wr_sel == SEL_INSTR)
               begin
                  instr <= INSTR_W'(merge({16'h0000, instr}, w_data, w_strb));
                  phase <= PH_DECODE;
               end
            end
            PH_DECODE:  phase <= PH_READ;
            PH_READ:    phase <= PH_PROCESS;
            PH_PROCESS: phase <= PH_WRITE;
            PH_WRITE:   phase <= PH_IDLE;
            default:    phase <= PH_IDLE;
         endcase
      end
   end

   // Decode phase: opcode class and unsupported flag
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         kind  <= K_NONE;
         unsup <= 1'b0;
      end
      else if (ce && phase == PH_DECODE)
      begin
         unsup <= 1'b0;
         if (instr[15:10] == OP_RLNC)
            kind <= K_RLNC;
         else if (instr[15:10] == OP_RRC)
            kind <= K_RRC;
         else if (instr[15:10] == OP_RRNC)
            kind <= K_RRNC;
         else if (instr[15:9] == OP_SET_REGISTER_ALL_ONES)
            kind <= K_SET_REGISTER_ALL_ONES;
         else
         begin
            kind  <= K_NONE;
            unsup <= 1'b1;
         end
      end
   end

   // Read phase: effective address and operand fetch
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         faddr   <= '0;
         operand <= '0;
      end
      else if (ce && phase == PH_READ)
      begin
         operand <= fdata;
         if (instr[IB_A])
            faddr <= {bank_select_register, instr[7:0]};
         else if (instr[7:0] < ACCESS_SPLIT)
            faddr <= {ACCESS_LO_BANK, instr[7:0]};
         else
            faddr <= {ACCESS_HI_BANK, instr[7:0]};
      end
   end

   // Process phase: rotate or fill
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         result <= '0;
         res_c  <= 1'b0;
      end
      else if (ce && phase == PH_PROCESS)
      begin
         res_c <= flag_c;
         case (kind)
            K_RLNC:  result <= {operand[6:0], operand[7]};
            K_RRC:
            begin
               result <= {flag_c, operand[7:1]};
               res_c  <= operand[0];
            end
            K_RRNC:  result <= {operand[0], operand[7:1]};
            K_SET_REGISTER_ALL_ONES:  result <= ALL_ONES;
            default: result <= operand;
         endcase
      end
   end

   // Working register
   always_ff @(posedge clk)
   begin
      if (srst)
         wreg <= '0;
      else if (ce)
      begin
         if (phase == PH_WRITE && kind != K_NONE && kind != K_SET_REGISTER_ALL_ONES && !instr[IB_D])
            wreg <= result;
         else if (!busy && wr_fire && wr_sel == SEL_WREG)
            wreg <= BYTE_W'(merge({24'h000000, wreg}, w_data, w_strb));
      end
   end

   // File operand register
   always_ff @(posedge clk)
   begin
      if (srst)
         fdata <= '0;
      else if (ce)
      begin
         if (phase == PH_WRITE && (kind == K_SET_REGISTER_ALL_ONES || (kind != K_NONE && instr[IB_D])))
            fdata <= result;
         else if (!busy && wr_fire && wr_sel == SEL_FDATA)
            fdata <= BYTE_W'(merge({24'h000000, fdata}, w_data, w_strb));
      end
   end

   // Bank select register
   always_ff @(posedge clk)
   begin
      if (srst)
         bank_select_register <= '0;
      else if (ce && !busy && wr_fire && wr_sel == SEL_BANK)
         bank_select_register <= BANK_W'(merge({28'h0000000, bank_select_register},
                                               w_data, w_strb));
   end

   // Status flags
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         flag_c <= 1'b0;
         flag_z <= 1'b0;
         flag_n <= 1'b0;
      end
      else if (ce)
      begin
         if (phase == PH_WRITE && kind != K_NONE && kind != K_SET_REGISTER_ALL_ONES)
         begin
            flag_n <= result[7];
            flag_z <= (result == BYTE_ZERO);
            flag_c <= res_c;
         end
         else if (!busy && wr_fire && wr_sel == SEL_STATUS && w_strb[0])
         begin
            flag_c <= w_data[ST_C];
            flag_z <= w_data[ST_Z];
            flag_n <= w_data[ST_N];
         end
      end
   end

endmodule : rsf_core

// >>> rsf_core_sva.sv
// Purpose: Bus timing and read-back checks on the rotate and set datapath ports
// Assumes: Only the top ports are visible; all checks on the one clock
// Notes:   Bind statement follows the module
`timescale 1ns/1ns
module rsf_core_sva
(
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic                  ce,
   input wire rsf_pkg::rsf_axi_req_t axi_req,
   input wire rsf_pkg::rsf_axi_rsp_t axi_rsp
);
   import rsf_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire logic ar_hs = ce && axi_req.arvalid && axi_rsp.arready;
   wire logic w_hs  = ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;

   AST_AR_ANSWER: assert property (ar_hs |=> axi_rsp.rvalid && !axi_rsp.arready)
      else $error("read answer late");
   AST_R_HOLD: assert property (axi_rsp.rvalid && !(ce && axi_req.rready)
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data not held");
   AST_R_DONE: assert property (axi_rsp.rvalid && ce && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read answer not released");
   AST_W_ANSWER: assert property (w_hs ##1 ce |=> axi_rsp.bvalid)
      else $error("write answer late");
   AST_B_HOLD: assert property (axi_rsp.bvalid && !(ce && axi_req.bready)
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer not held");
   AST_B_BLOCKS: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("new write accepted early");
   AST_WREG_NARROW: assert property (ar_hs && axi_req.araddr == OFS_WREG
      |=> axi_rsp.rdata[31:8] == 24'h0) else $error("working register upper bits set");
   AST_FADDR_NARROW: assert property (ar_hs && axi_req.araddr == OFS_FADDR
      |=> axi_rsp.rdata[31:12] == 20'h0 && axi_rsp.rresp == RESP_OKAY)
      else $error("file address read wrong");
   AST_UNMAPPED: assert property (ar_hs && axi_req.araddr == 8'h40
      |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read");

   COV_READ: cover property (ar_hs ##1 axi_rsp.rvalid);
   COV_WRITE: cover property (w_hs ##2 axi_rsp.bvalid);
   COV_STALL: cover property (axi_rsp.rvalid && !ce);
endmodule : rsf_core_sva

bind rsf_core rsf_core_sva rsf_core_sva_i (.clk(clk), .srst(srst), .ce(ce),
   .axi_req(axi_req), .axi_rsp(axi_rsp));

// >>> rsf_pkg.sv
// Purpose: Constants, types and bus carriers for the rotate and set datapath
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Byte offsets below are the AXI byte addresses
// How it works
// - Opcode 0100 01da rotates byte left, bit 7 into bit 0, sets N and Z.
// - Opcode 0011 00da rotates right through carry; updates C, N and Z.
// - Opcode 0100 00da rotates right, bit 0 into bit 7, sets N and Z.
// - Opcode 0110 100a writes all ones into the file register, flags untouched.
// - For rotates, d=0 sends result to working register, d=1 back to file.
// - a=0 addresses the fixed access bank; a=1 uses the bank select register.
package rsf_pkg;

   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          BYTE_W          = 8;
   localparam int          INSTR_W         = 16;
   localparam int          BANK_W          = 4;
   localparam int          FADDR_W         = 12;

   // Register byte offsets
   localparam logic [7:0]  OFS_INSTR       = 8'h00;
   localparam logic [7:0]  OFS_WREG        = 8'h04;
   localparam logic [7:0]  OFS_BANK        = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0c;
   localparam logic [7:0]  OFS_FDATA       = 8'h10;
   localparam logic [7:0]  OFS_FADDR       = 8'h14;

   // Status field positions
   localparam int          ST_C            = 0;
   localparam int          ST_Z            = 1;
   localparam int          ST_N            = 2;
   localparam int          ST_BUSY         = 8;
   localparam int          ST_UNSUP        = 9;

   // Opcode prefixes
   localparam logic [5:0]  OP_RLNC         = 6'h11;  // 0100 01
   localparam logic [5:0]  OP_RRC          = 6'h0c;  // 0011 00
   localparam logic [5:0]  OP_RRNC         = 6'h10;  // 0100 00
   localparam logic [6:0]  OP_SET_REGISTER_ALL_ONES         = 7'h34;  // 0110 100
   localparam int          IB_D            = 9;
   localparam int          IB_A            = 8;

   // Access bank split and the banks used for its lower and upper halves
   localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
   localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;

   localparam logic [7:0]  ALL_ONES        = 8'hff;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [2:0]
   {
      PH_IDLE    = 3'b000,
      PH_DECODE  = 3'b001,
      PH_READ    = 3'b010,
      PH_PROCESS = 3'b011,
      PH_WRITE   = 3'b100
   } rsf_phase_t;

   typedef enum logic [2:0]
   {
      K_NONE     = 3'b000,
      K_RLNC     = 3'b001,
      K_RRC      = 3'b010,
      K_RRNC     = 3'b011,
      K_SET_REGISTER_ALL_ONES     = 3'b100
   } rsf_kind_t;

   typedef enum logic [2:0]
   {
      SEL_NONE   = 3'b000,
      SEL_INSTR  = 3'b001,
      SEL_WREG   = 3'b010,
      SEL_BANK   = 3'b011,
      SEL_STATUS = 3'b100,
      SEL_FDATA  = 3'b101,
      SEL_FADDR  = 3'b110
   } rsf_sel_t;

   typedef struct packed
   {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } rsf_axi_req_t;

   typedef struct packed
   {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } rsf_axi_rsp_t;

endpackage : rsf_pkg
